//--- inc/dmam_defs.vh
// constants for the data memory address map block
`ifndef DMAM_DEFS_VH
`define DMAM_DEFS_VH
`define DMAM_SFR_SP 8'h81
`define DMAM_SFR_DPL 8'h82
`define DMAM_SFR_DPH 8'h83
`define DMAM_SFR_PAGE 8'haa
`define DMAM_SFR_PSW 8'hd0
`define DMAM_SFR_ACC 8'he0
`define DMAM_PSW_CY 7
`define DMAM_PSW_AC 6
`define DMAM_PSW_F0 5
`define DMAM_PSW_RSH 4
`define DMAM_PSW_RSL 3
`define DMAM_PSW_EXCEED 2
`define DMAM_PSW_UFLAG1 1
`define DMAM_PSW_PAR 0
`define DMAM_SP_RESET 8'h07
`define DMAM_PSW_RESET 8'h00
`define DMAM_FLASH_TOP 16'h3dff
`define DMAM_LOCK_ADDR 16'h3dff
`define DMAM_BIT_BASE 8'h20
`define DMAM_UPPER_BASE 8'h80
`define DMAM_OP_NONE 3'h0
`define DMAM_OP_ADD 3'h1
`define DMAM_OP_MUL 3'h2
`define DMAM_OP_DIV 3'h3
`define DMAM_OP_DIVZ 3'h4
`endif

//--- logic/dmam_iram.v
// internal 256-byte data ram with two read ports and one write port
`timescale 1ns/10ps
`default_nettype none
module dmam_iram #(
  parameter AW = 8
) (
  // clock
  input wire mclk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [7:0] wdata,
  // read ports
  input wire [AW-1:0] raddr_a,
  output wire [7:0] rdata_a,
  input wire [AW-1:0] raddr_b,
  output wire [7:0] rdata_b
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

//--- logic/dmam_onchip_external_ram.v
// on-chip external ram, one synchronous read/write port
`timescale 1ns/10ps
`default_nettype none
module dmam_onchip_external_ram #(
  parameter AW = 9
) (
  // clock
  input wire mclk,
  // access port
  input wire we,
  input wire re,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[addr];
    end
  end
endmodule
`default_nettype wire

//--- logic/dmam_core.v
// data memory address map: internal ram, banks, bits, stack, onchip_external_ram and flash routing
`timescale 1ns/10ps
`include "dmam_defs.vh"
`default_nettype none
module dmam_core #(
  parameter XAW = 9
) (
  // clock and reset
  input wire mclk,
  input wire rstn,
  // byte access request from the cpu
  input wire req,
  input wire req_wr,
  input wire req_ind,
  input wire req_bit,
  input wire req_reg,
  input wire req_ptr,
  input wire req_ptr_sel,
  input wire [2:0] req_regnum,
  input wire [7:0] req_addr,
  input wire [7:0] req_wdata,
  input wire req_wbit,
  // stack operations
  input wire push,
  input wire pop,
  input wire [7:0] push_data,
  // external move requests
  input wire xmov,
  input wire xmov_wr,
  input wire xmov_wide,
  input wire xmov_ptr_sel,
  input wire [7:0] xmov_wdata,
  input wire flash_write_mode,
  // code read requests
  input wire code_rd,
  input wire [15:0] code_addr,
  // arithmetic flag events
  input wire [2:0] arith_op,
  input wire arith_exceed,
  // answers
  output reg [7:0] rdata_q,
  output reg rbit_q,
  output reg rvalid_q,
  output reg sfr_sel_q,
  output reg [7:0] sfr_addr_q,
  output wire [7:0] onchip_external_ram_rdata_q,
  output reg xvalid_q,
  output reg flash_wr_q,
  output reg flash_rd_q,
  output reg [15:0] flash_addr_q,
  output reg flash_reserved_q,
  output reg flash_lock_q,
  output reg [7:0] stack_pointer_q,
  output reg [7:0] program_status_word_q,
  output reg [7:0] acc_q,
  output reg [7:0] onchip_external_ram_page_register_q
);
  function [7:0] bank_addr;
    input [1:0] bank;
    input [2:0] num;
    begin
      bank_addr = {3'h0, bank, num};
    end
  endfunction

  function [7:0] bit_byte;
    input [7:0] baddr;
    begin
      bit_byte = `DMAM_BIT_BASE + {4'h0, baddr[6:3]};
    end
  endfunction

  wire [1:0] bank_sel = {program_status_word_q[`DMAM_PSW_RSH], program_status_word_q[`DMAM_PSW_RSL]};
  wire [7:0] ptr_loc = bank_addr(bank_sel, {2'h0, req_ptr_sel});
  wire [7:0] xptr_loc = bank_addr(bank_sel, {2'h0, xmov_ptr_sel});
  wire [7:0] ptr_val;
  wire [7:0] xptr_val;
  wire [7:0] rd_byte;
  reg [7:0] dpair_lo_q;
  reg [7:0] dpair_hi_q;
  reg [7:0] sfr_rd;

  // effective address
  reg [7:0] ea;
  reg is_sfr;
  always @* begin
    is_sfr = 1'b0;
    if (req_bit) begin
      ea = bit_byte(req_addr);
      is_sfr = req_addr[7];
    end else if (req_reg) begin
      ea = bank_addr(bank_sel, req_regnum);
    end else if (req_ind) begin
      ea = ptr_val;
    end else begin
      ea = req_addr;
      is_sfr = req_addr[7];
    end
    if (req_bit && req_addr[7]) begin
      ea = {req_addr[7:3], 3'h0};
    end
  end

  wire [7:0] sp_inc = stack_pointer_q + 8'h01;
  wire ram_push = push;
  wire ram_req_wr = req && req_wr && !is_sfr && !push;
  reg [7:0] wr_val;
  always @* begin
    wr_val = req_wdata;
    if (req_bit) begin
      // read-modify-write must start from the space the bit lives in
      wr_val = is_sfr ? sfr_rd : rd_byte;
      wr_val[req_addr[2:0]] = req_wbit;
    end
  end
  wire iram_we = ram_push || ram_req_wr;
  wire [7:0] iram_waddr = ram_push ? sp_inc : ea;
  wire [7:0] iram_wdata = ram_push ? push_data : wr_val;
  wire [7:0] raddr_a = pop ? stack_pointer_q : ea;
  wire [7:0] raddr_b = xmov ? xptr_loc : ptr_loc;
  assign xptr_val = ptr_val;

  dmam_iram #(
    .AW(8)
  ) u_iram (
    .mclk(mclk),
    .we(iram_we),
    .waddr(iram_waddr),
    .wdata(iram_wdata),
    .raddr_a(raddr_a),
    .rdata_a(rd_byte),
    .raddr_b(raddr_b),
    .rdata_b(ptr_val)
  );

  // external move routing
  wire [XAW-1:0] xaddr = xmov_wide ? {dpair_hi_q[XAW-9:0], dpair_lo_q}
                                   : {onchip_external_ram_page_register_q[XAW-9:0], xptr_val};
  wire x_to_flash = xmov_wr && flash_write_mode;
  dmam_onchip_external_ram #(
    .AW(XAW)
  ) u_onchip_external_ram (
    .mclk(mclk),
    .we(xmov && xmov_wr && !x_to_flash),
    .re(xmov && !xmov_wr),
    .addr(xaddr),
    .wdata(xmov_wdata),
    .rdata_q(onchip_external_ram_rdata_q)
  );

  wire [15:0] x16 = xmov_wide ? {dpair_hi_q, dpair_lo_q} : {onchip_external_ram_page_register_q, xptr_val};
  wire [15:0] fl_addr = (xmov && x_to_flash) ? x16 : code_addr;
  wire sfr_wr = req && req_wr && is_sfr;
  wire [7:0] sfr_wbyte = req_bit ? wr_val : req_wdata;

  // special function register readback
  always @* begin
    case (ea)
      `DMAM_SFR_SP: sfr_rd = stack_pointer_q;
      `DMAM_SFR_DPL: sfr_rd = dpair_lo_q;
      `DMAM_SFR_DPH: sfr_rd = dpair_hi_q;
      `DMAM_SFR_PAGE: sfr_rd = {7'h00, onchip_external_ram_page_register_q[0]};
      `DMAM_SFR_PSW: sfr_rd = program_status_word_q;
      `DMAM_SFR_ACC: sfr_rd = acc_q;
      default: sfr_rd = 8'h00;
    endcase
  end
  wire [7:0] byte_out = is_sfr ? sfr_rd : rd_byte;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
      rvalid_q <= 1'b0;
      sfr_sel_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      xvalid_q <= 1'b0;
      flash_wr_q <= 1'b0;
      flash_rd_q <= 1'b0;
      flash_addr_q <= 16'h0000;
      flash_reserved_q <= 1'b0;
      flash_lock_q <= 1'b0;
      stack_pointer_q <= `DMAM_SP_RESET;
      program_status_word_q <= `DMAM_PSW_RESET;
      acc_q <= 8'h00;
      onchip_external_ram_page_register_q <= 8'h00;
      dpair_lo_q <= 8'h00;
      dpair_hi_q <= 8'h00;
    end else begin
      rvalid_q <= (req && !req_wr) || pop;
      rdata_q <= pop ? rd_byte : byte_out;
      rbit_q <= byte_out[req_addr[2:0]];
      sfr_sel_q <= req && is_sfr;
      sfr_addr_q <= ea;
      xvalid_q <= xmov && !xmov_wr;
      flash_rd_q <= code_rd;
      flash_wr_q <= xmov && x_to_flash;
      flash_addr_q <= fl_addr;
      flash_reserved_q <= (code_rd || (xmov && x_to_flash)) && (fl_addr > `DMAM_FLASH_TOP);
      flash_lock_q <= (code_rd || (xmov && x_to_flash)) && (fl_addr == `DMAM_LOCK_ADDR);
      if (push) begin
        stack_pointer_q <= sp_inc;
      end else if (pop) begin
        stack_pointer_q <= stack_pointer_q - 8'h01;
      end else if (sfr_wr && ea == `DMAM_SFR_SP) begin
        stack_pointer_q <= sfr_wbyte;
      end
      if (sfr_wr && ea == `DMAM_SFR_DPL) begin
        dpair_lo_q <= sfr_wbyte;
      end
      if (sfr_wr && ea == `DMAM_SFR_DPH) begin
        dpair_hi_q <= sfr_wbyte;
      end
      if (sfr_wr && ea == `DMAM_SFR_PAGE) begin
        onchip_external_ram_page_register_q <= {7'h00, sfr_wbyte[0]};
      end
      if (sfr_wr && ea == `DMAM_SFR_ACC) begin
        acc_q <= sfr_wbyte;
      end
      if (sfr_wr && ea == `DMAM_SFR_PSW) begin
        program_status_word_q[7:1] <= sfr_wbyte[7:1];
      end else begin
        case (arith_op)
          `DMAM_OP_DIVZ: program_status_word_q[`DMAM_PSW_EXCEED] <= 1'b1;
          `DMAM_OP_ADD: program_status_word_q[`DMAM_PSW_EXCEED] <= arith_exceed;
          `DMAM_OP_MUL: program_status_word_q[`DMAM_PSW_EXCEED] <= arith_exceed;
          `DMAM_OP_DIV: program_status_word_q[`DMAM_PSW_EXCEED] <= 1'b0;
          default: program_status_word_q[`DMAM_PSW_EXCEED] <= program_status_word_q[`DMAM_PSW_EXCEED];
        endcase
      end
      program_status_word_q[`DMAM_PSW_PAR] <= ^((sfr_wr && ea == `DMAM_SFR_ACC) ? sfr_wbyte : acc_q);
    end
  end
endmodule
`default_nettype wire

//--- test/dmam_core_chk.sv
// port assertions for the data memory address map
`timescale 1ns/10ps
`default_nettype none
module dmam_core_chk (
  input wire logic mclk, rstn, req, req_ind, req_bit, req_reg, push, xmov, xmov_wr, flash_write_mode,
  input wire logic code_rd, arith_exceed, flash_lock_q, flash_reserved_q, flash_wr_q, sfr_sel_q,
  input wire logic [2:0] arith_op,
  input wire logic [7:0] req_addr, stack_pointer_q, program_status_word_q, acc_q, onchip_external_ram_page_register_q,
  input wire logic [15:0] code_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sp_push_a: assert property (push |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01)
    else $error("stack pointer did not step");
  page_zero_a: assert property (onchip_external_ram_page_register_q[7:1] == 7'h00)
    else $error("page register high bits set");
  parity_acc_a: assert property (program_status_word_q[0] == ^acc_q)
    else $error("parity flag wrong");
  exceed_divz_a: assert property (arith_op == 3'h4 && !req |=> program_status_word_q[2])
    else $error("overflow not set");
  exceed_clear_a: assert property (arith_op inside {3'h1, 3'h2, 3'h3} && !arith_exceed && !req |=> !program_status_word_q[2])
    else $error("overflow not cleared");
  lock_byte_a: assert property (code_rd && code_addr == 16'h3dff |=> flash_lock_q && !flash_reserved_q)
    else $error("lock byte not flagged");
  reserved_a: assert property (code_rd && code_addr > 16'h3dff |=> flash_reserved_q && !flash_lock_q)
    else $error("reserved area not flagged");
  flash_wr_a: assert property (xmov && xmov_wr && flash_write_mode |=> flash_wr_q)
    else $error("flash write not routed");
  direct_sfr_a: assert property (req && !req_ind && !req_bit && !req_reg && req_addr == 8'h90 |=> sfr_sel_q)
    else $error("direct access missed special space");
  indirect_ram_a: assert property (req && req_ind |=> !sfr_sel_q)
    else $error("indirect access hit special space");
endmodule
bind dmam_core dmam_core_chk u_dmam_core_chk (.*);
`default_nettype wire

//--- test/dmam_cpu_model.sv
// cpu-side model: one request per access, strobes dropped after the taking edge
`timescale 1ns/10ps
`default_nettype none
module dmam_cpu_model (
  input wire logic mclk,
  output logic req, req_wr, req_ind, req_bit, req_reg, req_ptr, req_ptr_sel, req_wbit, push, pop,
  output logic xmov, xmov_wr, xmov_wide, xmov_ptr_sel, flash_write_mode, code_rd, arith_exceed,
  output logic [2:0] req_regnum, arith_op,
  output logic [7:0] req_addr, req_wdata, push_data, xmov_wdata,
  output logic [15:0] code_addr
);
  task automatic idle();
    {req, req_wr, req_ind, req_bit, req_reg, req_ptr, push, pop, xmov, xmov_wr, code_rd, arith_exceed, arith_op} = '0;
  endtask
  task automatic go();
    @(negedge mclk);
    idle();
  endtask
  initial begin
    idle();
    {req_ptr_sel, req_wbit, xmov_wide, xmov_ptr_sel, flash_write_mode, req_regnum, req_addr, req_wdata} = '0;
    {push_data, xmov_wdata, code_addr} = '0;
  end
  task automatic acc(input logic wr, ind, bt, rg, input logic [2:0] n, input logic [7:0] a, d);
    @(negedge mclk);
    {req, req_wr, req_ind, req_bit, req_reg, req_regnum} = {1'b1, wr, ind, bt, rg, n};
    {req_ptr_sel, req_addr, req_wdata, req_wbit} = {n[0], a, d, d[0]};
    go();
  endtask
  task automatic stk(input logic p, input logic [7:0] d);
    @(negedge mclk);
    {push, pop, push_data} = {p, !p, d};
    go();
  endtask
  task automatic xm(input logic wr, dp, fm, input logic [7:0] d);
    @(negedge mclk);
    {xmov, xmov_wr, xmov_wide, xmov_ptr_sel, flash_write_mode, xmov_wdata} = {1'b1, wr, dp, 1'b1, fm, d};
    go();
  endtask
  task automatic cr(input logic [15:0] a);
    @(negedge mclk);
    {code_rd, code_addr} = {1'b1, a};
    go();
  endtask
  task automatic ar(input logic [2:0] op, input logic ex);
    @(negedge mclk);
    {arith_op, arith_exceed} = {op, ex};
    go();
  endtask
endmodule
`default_nettype wire

//--- test/dmam_core_tb_top.sv
// self-checking bench for the data memory address map
`timescale 1ns/10ps
`default_nettype none
module dmam_core_tb_top;
  logic mclk, rstn, req, req_wr, req_ind, req_bit, req_reg, req_ptr, req_ptr_sel, req_wbit, push, pop;
  logic xmov, xmov_wr, xmov_wide, xmov_ptr_sel, flash_write_mode, code_rd, arith_exceed, rbit_q, rvalid_q;
  logic sfr_sel_q, xvalid_q, flash_wr_q, flash_rd_q, flash_reserved_q, flash_lock_q;
  logic [2:0] req_regnum, arith_op;
  logic [7:0] req_addr, req_wdata, push_data, xmov_wdata, rdata_q, sfr_addr_q, onchip_external_ram_rdata_q;
  logic [7:0] stack_pointer_q, program_status_word_q, acc_q, onchip_external_ram_page_register_q;
  logic [15:0] code_addr, flash_addr_q;
  int bad_count, tests_run;
  dmam_core u_dmam_core (.*);
  dmam_cpu_model u_dmam_cpu_model (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wd(input logic [7:0] a, d);
    u_dmam_cpu_model.acc(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    u_dmam_cpu_model.acc(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, a, 8'h00);
    chk("direct read", {rvalid_q, rdata_q}, {8'h01, exp});
  endtask
  task automatic t_stack();
    chk("reset sp", stack_pointer_q, 8'h07);
    u_dmam_cpu_model.stk(1'b1, 8'ha5);
    chk("sp after push", stack_pointer_q, 8'h08);
    rd(8'h08, 8'ha5);
    u_dmam_cpu_model.stk(1'b0, 8'h00);
    chk("pop data", {rdata_q, stack_pointer_q}, 16'ha507);
    wd(8'h81, 8'hff);
    u_dmam_cpu_model.stk(1'b1, 8'h3c);
    rd(8'h00, 8'h3c);
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wd(8'hd0, {3'h0, b[1:0], 3'h0});
      u_dmam_cpu_model.acc(1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 8'h00, 8'h40 + b[7:0]);
      rd({3'h0, b[1:0], 3'h2}, 8'h40 + b[7:0]);
    end
    u_dmam_cpu_model.acc(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 8'h90);
    u_dmam_cpu_model.acc(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 8'h00, 8'h30);
    rd(8'h18, 8'h90);
    u_dmam_cpu_model.acc(1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00, 8'h55);
    u_dmam_cpu_model.acc(1'b1, 1'b1, 1'b0, 1'b0, 3'h1, 8'h00, 8'h66);
    u_dmam_cpu_model.acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
    chk("upper ram", rdata_q, 8'h55);
    rd(8'h30, 8'h66);
    u_dmam_cpu_model.acc(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 8'h90, 8'h00);
    chk("special space", {sfr_sel_q, sfr_addr_q}, 16'h0190);
  endtask
  task automatic t_bits();
    wd(8'h22, 8'h00);
    u_dmam_cpu_model.acc(1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 8'h13, 8'h01);
    rd(8'h22, 8'h08);
    wd(8'h2f, 8'h80);
    u_dmam_cpu_model.acc(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h7f, 8'h00);
    chk("bit read", rbit_q, 1'b1);
  endtask
  task automatic t_onchip_external_ram();
    wd(8'haa, 8'hff);
    chk("page register", onchip_external_ram_page_register_q, 8'h01);
    u_dmam_cpu_model.xm(1'b1, 1'b0, 1'b0, 8'h77);
    wd(8'h83, 8'hfb);
    wd(8'h82, 8'h30);
    u_dmam_cpu_model.xm(1'b0, 1'b1, 1'b0, 8'h00);
    chk("onchip_external_ram alias", {xvalid_q, onchip_external_ram_rdata_q}, 9'h177);
    u_dmam_cpu_model.cr(16'h3dff);
    chk("lock byte", flash_lock_q, 1'b1);
    u_dmam_cpu_model.cr(16'h3e00);
    chk("reserved", flash_reserved_q, 1'b1);
    u_dmam_cpu_model.xm(1'b1, 1'b0, 1'b1, 8'h12);
    chk("flash write", {flash_wr_q, xvalid_q}, 2'b10);
    chk("flash address", flash_addr_q, 16'h0130);
    u_dmam_cpu_model.cr(16'h1234);
    chk("code read", flash_rd_q, 1'b1);
  endtask
  task automatic t_flags();
    u_dmam_cpu_model.ar(3'h4, 1'b0);
    chk("overflow set", program_status_word_q[2], 1'b1);
    u_dmam_cpu_model.ar(3'h3, 1'b0);
    chk("overflow clear", program_status_word_q[2], 1'b0);
    wd(8'he0, 8'h07);
    u_dmam_cpu_model.go();
    chk("parity", program_status_word_q[0], 1'b1);
    chk("accumulator", acc_q, 8'h07);
  endtask
  initial begin
    rstn = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    t_stack();
    t_banks();
    t_bits();
    t_onchip_external_ram();
    t_flags();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
